// ---- core/nlsp_decoder.sv ----
// Load/exchange/table/pointer/flag instruction group of a nibble core
`timescale 1ns/1ps
module nlsp_decoder
    import nlsp_pkg::*;
(
    // Clock and reset
    input  wire logic                 MCLK,
    input  wire logic                 RST_B,
    // Instruction from the fetch unit
    input  wire logic                 INSTR_VALID,
    input  wire logic [BYTE_W-1:0]    OPCODE,
    input  wire logic [BYTE_W-1:0]    OPERAND,
    output logic                      INSTR_HIT,
    output logic                      INSTR_READY,
    output logic                      INSTR_DONE,
    // Program ROM access
    input  wire logic [PC_W-1:0]      PC_IN,
    output logic [PC_W-1:0]           ROM_ADDR,
    input  wire logic [BYTE_W-1:0]    ROM_DATA,
    // Port latches
    output logic [NIB_W-1:0]          PORT4,
    output logic [NIB_W-1:0]          PORT5,
    output logic                      PORT_STROBE,
    // Core state
    output logic [NIB_W-1:0]          ACC,
    output logic [NIB_W-1:0]          EXT,
    output logic [NIB_W-1:0]          PRIMARY_HIGH_POINTER,
    output logic [NIB_W-1:0]          PRIMARY_LOW_POINTER,
    output logic [NIB_W-1:0]          SECONDARY_HIGH_POINTER,
    output logic [NIB_W-1:0]          SECONDARY_LOW_POINTER,
    output logic                      ZERO_FLAG,
    output logic [FLAG_COUNT-1:0]     USER_FLAG_BIT
);

    nlsp_state_type state;
    nlsp_state_type next_state;

    logic [NIB_W-1:0]      acc;
    logic [NIB_W-1:0]      ext;
    logic [NIB_W-1:0]      ptr [PTR_COUNT];
    logic                  zero_flag;
    logic [FLAG_COUNT-1:0] user_flag_bit;
    logic [NIB_W-1:0]      data_mem [MEM_DEPTH];
    logic [BYTE_W-1:0]     held_op;
    logic [BYTE_W-1:0]     held_opnd;
    logic [PC_W-1:0]       rom_addr;
    logic [NIB_W-1:0]      port4;
    logic [NIB_W-1:0]      port5;
    logic                  port_strobe;
    logic                  done;

    logic [NIB_W-1:0]      next_acc;
    logic [NIB_W-1:0]      next_ext;
    logic [NIB_W-1:0]      next_ptr [PTR_COUNT];
    logic                  next_zero;
    logic [FLAG_COUNT-1:0] next_flags;
    logic                  mem_we;

    // Zero detection used wherever the flag is updated
    function automatic logic is_zero(input logic [NIB_W-1:0] v);
        return v == NIB_RESET;
    endfunction

    // Operation under decode: live opcode when idle, held one after
    wire         idle      = state == NLSP_IDLE;
    wire [7:0]   op        = idle ? OPCODE : held_op;
    wire [7:0]   opnd      = idle ? OPERAND : held_opnd;
    wire [7:0]   op_pair   = op & MASK_PAIR;
    wire         sec       = op[1];

    // Group decode
    wire d_load      = op_pair == OP_LOAD;
    wire d_load_inc  = op_pair == OP_LOAD_INC;
    wire d_load_dec  = op_pair == OP_LOAD_DEC;
    wire d_swap      = op_pair == OP_SWAP;
    wire d_swap_inc  = op_pair == OP_SWAP_INC;
    wire d_swap_dec  = op_pair == OP_SWAP_DEC;
    wire d_step_up   = op_pair == OP_STEP_UP;
    wire d_step_dn   = op_pair == OP_STEP_DN;
    wire d_swap_dir  = op == OP_SWAP_DIR;
    wire d_ld_extacc = op == OP_LD_EXTACC;
    wire d_tbl       = op == OP_TBL;
    wire d_tbl_port  = op == OP_TBL_PORT;
    wire d_zero_ld   = (op & MASK_HIGH) == OP_ZERO_LD;
    wire d_ld_pair   = op_pair == OP_LD_PAIR;
    wire d_ld_high   = op == OP_PFX_IMM && (opnd & MASK_HIGH) == IMM_LD_HIGH;
    wire d_ld_low    = op == OP_PFX_IMM && (opnd & MASK_HIGH) == IMM_LD_LOW;
    wire d_swap_ptr  = (op & MASK_NIB) == OP_SWAP_PTR;
    wire d_xfer      = op == OP_PFX_XFER && (opnd & MASK_XFER) == XFER_BASE;
    wire d_set_flag  = (op & MASK_HIGH) == OP_SET_FLAG;
    wire d_clr_flag  = (op & MASK_HIGH) == OP_CLR_FLAG;

    // Pointer stepping shared by memory forms and plain steps
    wire post_inc  = d_load_inc | d_swap_inc;
    wire post_dec  = d_load_dec | d_swap_dec;
    wire any_inc   = post_inc | d_step_up;
    wire any_dec   = post_dec | d_step_dn;
    wire [1:0] low_sel = sec ? PTR_SL : PTR_PL;
    wire [NIB_W-1:0] low_val = ptr[low_sel];
    wire [NIB_W-1:0] stepped = any_inc ? NIB_W'(low_val + 4'h1)
                                       : NIB_W'(low_val - 4'h1);

    // Memory addressing: selected pair or the second byte
    wire [7:0] pair_addr = sec ? {ptr[PTR_SH], ptr[PTR_SL]}
                               : {ptr[PTR_PH], ptr[PTR_PL]};
    wire [7:0] mem_addr  = d_swap_dir ? opnd : pair_addr;
    wire [NIB_W-1:0] mem_rd = data_mem[mem_addr];

    // Transfer fields
    wire [1:0] nib_sel   = d_xfer ? opnd[1:0] : op[1:0];
    wire       to_ptr    = opnd[XFER_DIR_B];
    wire [3:0] flag_sel  = op[3:0];
    wire [1:0] flag_grp  = flag_sel[3:2];

    wire one_cycle = d_load | d_swap | d_step_up | d_step_dn | d_zero_ld
                   | d_swap_ptr | d_set_flag | d_clr_flag;
    wire two_cycle = post_inc | post_dec | d_swap_dir | d_ld_extacc
                   | d_tbl | d_tbl_port | d_ld_pair | d_ld_high
                   | d_ld_low | d_xfer;

    wire take     = idle && INSTR_VALID && (one_cycle || two_cycle);
    wire take_two = take && two_cycle;
    wire commit   = (take && one_cycle) || state == NLSP_WAIT;

    assign INSTR_HIT   = one_cycle || two_cycle;
    assign INSTR_READY = idle;
    assign INSTR_DONE  = done;
    assign ROM_ADDR    = rom_addr;
    assign PORT4       = port4;
    assign PORT5       = port5;
    assign PORT_STROBE = port_strobe;
    assign ACC         = acc;
    assign EXT         = ext;
    assign ZERO_FLAG   = zero_flag;
    assign USER_FLAG_BIT = user_flag_bit;
    assign PRIMARY_HIGH_POINTER   = ptr[PTR_PH];
    assign PRIMARY_LOW_POINTER    = ptr[PTR_PL];
    assign SECONDARY_HIGH_POINTER = ptr[PTR_SH];
    assign SECONDARY_LOW_POINTER  = ptr[PTR_SL];

    // Next architectural state for the operation under decode
    always_comb begin
        next_acc   = acc;
        next_ext   = ext;
        next_ptr   = ptr;
        next_zero  = zero_flag;
        next_flags = user_flag_bit;
        mem_we     = 1'b0;
        if (d_load || post_inc || post_dec) begin
            next_acc  = mem_rd;
            next_zero = is_zero(mem_rd);
        end
        if (d_swap || d_swap_inc || d_swap_dec || d_swap_dir) begin
            next_acc = mem_rd;
            mem_we   = 1'b1;
        end
        if (any_inc || any_dec) begin
            next_ptr[low_sel] = stepped;
            next_zero         = is_zero(stepped);
        end
        if (d_ld_extacc) begin
            next_ext = opnd[7:4];
            next_acc = opnd[3:0];
        end
        if (d_tbl) begin
            next_ext = ROM_DATA[7:4];
            next_acc = ROM_DATA[3:0];
        end
        if (d_zero_ld) begin
            next_ptr[PTR_PH] = NIB_RESET;
            next_ptr[PTR_PL] = op[3:0];
        end
        if (d_ld_high)
            next_ptr[PTR_PH] = opnd[3:0];
        if (d_ld_low)
            next_ptr[PTR_PL] = opnd[3:0];
        if (d_ld_pair) begin
            next_ptr[sec ? PTR_SH : PTR_PH] = opnd[7:4];
            next_ptr[sec ? PTR_SL : PTR_PL] = opnd[3:0];
        end
        if (d_swap_ptr) begin
            next_ptr[nib_sel] = acc;
            next_acc          = ptr[nib_sel];
        end
        if (d_xfer && to_ptr)
            next_ptr[nib_sel] = acc;
        if (d_xfer && !to_ptr) begin
            next_acc  = ptr[nib_sel];
            next_zero = is_zero(ptr[nib_sel]);
        end
        if (d_set_flag)
            next_flags[flag_sel] = 1'b1;
        if (d_clr_flag) begin
            next_flags[flag_sel] = 1'b0;
            next_zero = is_zero(next_flags[flag_grp*4 +: 4]);
        end
    end

    assign next_state = take_two ? NLSP_WAIT : NLSP_IDLE;

    // Sequencer and held instruction bytes
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            state     <= NLSP_IDLE;
            held_op   <= BYTE_RESET;
            held_opnd <= BYTE_RESET;
            done      <= 1'b0;
        end else begin
            state <= next_state;
            done  <= commit;
            if (take) begin
                held_op   <= OPCODE;
                held_opnd <= OPERAND;
            end
        end
    end

    // Registers change only when an operation completes
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            acc           <= NIB_RESET;
            ext           <= NIB_RESET;
            zero_flag     <= 1'b0;
            user_flag_bit <= FLAG_RESET;
        end else if (commit) begin
            acc           <= next_acc;
            ext           <= next_ext;
            zero_flag     <= next_zero;
            user_flag_bit <= next_flags;
        end
    end

    // One flop per pointer nibble
    for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
        always_ff @(posedge MCLK) begin
            if (!RST_B)
                ptr[i] <= NIB_RESET;
            else if (commit)
                ptr[i] <= next_ptr[i];
        end
    end

    // Data memory has no reset; contents are undefined at power-up
    always_ff @(posedge MCLK) begin
        if (commit && mem_we)
            data_mem[mem_addr] <= acc;
    end

    // ROM address formed at take so data is ready on the second edge
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            rom_addr    <= ROM_RESET;
            port4       <= NIB_RESET;
            port5       <= NIB_RESET;
            port_strobe <= 1'b0;
        end else begin
            port_strobe <= commit && d_tbl_port;
            if (take && (d_tbl || d_tbl_port))
                rom_addr <= {PC_IN[PC_W-1:PC_HI_LSB], ext, acc};
            if (commit && d_tbl_port) begin
                port4 <= ROM_DATA[3:0];
                port5 <= ROM_DATA[7:4];
            end
        end
    end

    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence take_slow;
        idle && INSTR_VALID && two_cycle;
    endsequence
    sequence finish_slow;
        state == NLSP_WAIT ##1 (idle && done);
    endsequence

    two_cycle_seq_a: assert property (take_slow |=> finish_slow)
        else $error("two-cycle instruction did not finish on time");
    inc_zero_a: assert property (commit && any_inc && !sec |=>
        ptr[PTR_PL] == NIB_W'($past(ptr[PTR_PL]) + 4'h1)
        && zero_flag == (ptr[PTR_PL] == 4'h0))
        else $error("increment did not set zero flag from pointer");
    dec_zero_a: assert property (commit && any_dec && sec |=>
        ptr[PTR_SL] == NIB_W'($past(ptr[PTR_SL]) - 4'h1)
        && zero_flag == (ptr[PTR_SL] == 4'h0))
        else $error("decrement did not set zero flag from pointer");
    load_data_a: assert property (commit && post_inc && !mem_we |=>
        acc == $past(mem_rd))
        else $error("load did not deliver memory nibble");
    plain_swap_a: assert property (commit && d_swap |=>
        $stable(zero_flag) && $stable(ptr[PTR_PL]) && $stable(ptr[PTR_SL]))
        else $error("plain swap changed pointers or zero flag");
    ext_acc_a: assert property (commit && d_ld_extacc |=>
        ext == $past(opnd[7:4]) && acc == $past(opnd[3:0]))
        else $error("immediate byte split wrong");
    table_port_a: assert property (commit && d_tbl_port |=>
        port_strobe && port4 == $past(ROM_DATA[3:0])
        && port5 == $past(ROM_DATA[7:4]) && $stable(acc))
        else $error("table-to-port output wrong");
    zero_page_a: assert property (commit && d_zero_ld |=>
        ptr[PTR_PH] == 4'h0 && ptr[PTR_PL] == $past(op[3:0]))
        else $error("zero-page pointer load wrong");
    xfer_flag_a: assert property (commit && d_xfer && to_ptr |=>
        $stable(zero_flag))
        else $error("transfer to pointer touched zero flag");
    set_flag_a: assert property (commit && d_set_flag |=>
        user_flag_bit[$past(flag_sel)] && $stable(zero_flag))
        else $error("set flag failed or touched zero flag");
    clr_flag_a: assert property (commit && d_clr_flag |=>
        !user_flag_bit[$past(flag_sel)])
        else $error("clear flag failed");

endmodule // nlsp_decoder

// ---- core/nlsp_pkg.sv ----
// Constants, opcodes and state type for the load/store/pointer decoder
package nlsp_pkg;

    // Widths
    localparam int NIB_W      = 4;
    localparam int BYTE_W     = 8;
    localparam int PC_W       = 13;
    localparam int PC_HI_LSB  = 8;
    localparam int MEM_DEPTH  = 256;
    localparam int FLAG_COUNT = 16;
    localparam int PTR_COUNT  = 4;

    // Pointer nibble indices
    localparam logic [1:0] PTR_PH = 2'h0;
    localparam logic [1:0] PTR_PL = 2'h1;
    localparam logic [1:0] PTR_SH = 2'h2;
    localparam logic [1:0] PTR_SL = 2'h3;

    // Reset values
    localparam logic [3:0]  NIB_RESET  = 4'h0;
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    localparam logic [12:0] ROM_RESET  = 13'h0000;

    // Opcode masks: bit 1 is the pair select
    localparam logic [7:0] MASK_PAIR  = 8'hFD;
    localparam logic [7:0] MASK_NIB   = 8'hFC;
    localparam logic [7:0] MASK_HIGH  = 8'hF0;

    // One-byte opcodes (compared after masking, except OP_TBL and OP_TBL_PORT, compared exactly)
    localparam logic [7:0] OP_LOAD     = 8'h48;
    localparam logic [7:0] OP_LOAD_INC = 8'h49;
    localparam logic [7:0] OP_LOAD_DEC = 8'h59;
    localparam logic [7:0] OP_SWAP     = 8'h4C;
    localparam logic [7:0] OP_SWAP_INC = 8'h4D;
    localparam logic [7:0] OP_SWAP_DEC = 8'h5D;
    localparam logic [7:0] OP_TBL      = 8'h5A;
    localparam logic [7:0] OP_TBL_PORT = 8'h58;
    localparam logic [7:0] OP_ZERO_LD  = 8'h60;
    localparam logic [7:0] OP_STEP_UP  = 8'h11;
    localparam logic [7:0] OP_STEP_DN  = 8'h21;
    localparam logic [7:0] OP_SWAP_PTR = 8'h40;
    localparam logic [7:0] OP_SET_FLAG = 8'h70;
    localparam logic [7:0] OP_CLR_FLAG = 8'h30;

    // Two-byte opcodes (first byte)
    localparam logic [7:0] OP_SWAP_DIR  = 8'hCC;
    localparam logic [7:0] OP_LD_EXTACC = 8'hC6;
    localparam logic [7:0] OP_LD_PAIR   = 8'hC0;
    localparam logic [7:0] OP_PFX_IMM   = 8'hCF;
    localparam logic [7:0] OP_PFX_XFER  = 8'hEF;

    // Second-byte patterns for prefixed forms
    localparam logic [7:0] IMM_LD_HIGH = 8'h00;
    localparam logic [7:0] IMM_LD_LOW  = 8'h10;
    localparam logic [7:0] MASK_XFER   = 8'hEC;
    localparam logic [7:0] XFER_BASE   = 8'hC0;
    localparam int         XFER_DIR_B  = 4;

    typedef enum logic {
        NLSP_IDLE = 1'b0,
        NLSP_WAIT = 1'b1
    } nlsp_state_type;

endpackage

// ---- test/nlsp_decoder_bench.sv ----
// Self-checking bench for the load/store/pointer decoder
`timescale 1ns/1ps
module nlsp_decoder_bench;
    import nlsp_pkg::*;

    typedef struct {
        logic [7:0]  op;
        logic [7:0]  opnd;
        int          cyc;
        logic [3:0]  acc;
        logic [3:0]  ext;
        logic [15:0] ptr;
        logic        zf;
    } nlsp_row_type;

    logic        mclk, rst_b, valid, hit, ready, done, strobe, zf;
    logic [7:0]  opcode, operand, rom_data, e;
    logic [12:0] pc_in, rom_addr;
    logic [3:0]  acc, ext, ph, pl, sh, sl, port4, port5;
    logic [15:0] uf;
    int          errors = 0;
    int          tests_run = 0;
    int          n;

    // Rows: opcode, operand, cycles, then acc, ext, {ph,pl,sh,sl}, zero flag
    nlsp_row_type rows [39] = '{
    '{8'hC6, 8'hA5, 2, 4'h5, 4'hA, 16'h0000, 1'b0},
    '{8'hC0, 8'h3C, 2, 4'h5, 4'hA, 16'h3C00, 1'b0},
    '{8'hC2, 8'h7F, 2, 4'h5, 4'hA, 16'h3C7F, 1'b0},
    '{8'h48, 8'h00, 1, 4'h9, 4'hA, 16'h3C7F, 1'b0},
    '{8'h49, 8'h00, 2, 4'h9, 4'hA, 16'h3D7F, 1'b0},
    '{8'h4B, 8'h00, 2, 4'h2, 4'hA, 16'h3D70, 1'b1},
    '{8'h59, 8'h00, 2, 4'h0, 4'hA, 16'h3C70, 1'b0},
    '{8'h5B, 8'h00, 2, 4'hE, 4'hA, 16'h3C7F, 1'b0},
    '{8'h4C, 8'h00, 1, 4'h9, 4'hA, 16'h3C7F, 1'b0},
    '{8'h4D, 8'h00, 2, 4'hE, 4'hA, 16'h3D7F, 1'b0},
    '{8'h5F, 8'h00, 2, 4'h2, 4'hA, 16'h3D7E, 1'b0},
    '{8'h5D, 8'h00, 2, 4'h0, 4'hA, 16'h3C7E, 1'b0},
    '{8'h11, 8'h00, 1, 4'h0, 4'hA, 16'h3D7E, 1'b0},
    '{8'h23, 8'h00, 1, 4'h0, 4'hA, 16'h3D7D, 1'b0},
    '{8'h21, 8'h00, 1, 4'h0, 4'hA, 16'h3C7D, 1'b0},
    '{8'h13, 8'h00, 1, 4'h0, 4'hA, 16'h3C7E, 1'b0},
    '{8'h67, 8'h00, 1, 4'h0, 4'hA, 16'h077E, 1'b0},
    '{8'h60, 8'h00, 1, 4'h0, 4'hA, 16'h007E, 1'b0},
    '{8'h21, 8'h00, 1, 4'h0, 4'hA, 16'h0F7E, 1'b0},
    '{8'h11, 8'h00, 1, 4'h0, 4'hA, 16'h007E, 1'b1},
    '{8'hCC, 8'h3C, 2, 4'h9, 4'hA, 16'h007E, 1'b1},
    '{8'hEF, 8'hD2, 2, 4'h9, 4'hA, 16'h009E, 1'b1},
    '{8'hEF, 8'hC3, 2, 4'hE, 4'hA, 16'h009E, 1'b0},
    '{8'hEF, 8'hC1, 2, 4'h0, 4'hA, 16'h009E, 1'b1},
    '{8'hC6, 8'h4B, 2, 4'hB, 4'h4, 16'h009E, 1'b1},
    '{8'hEF, 8'hD0, 2, 4'hB, 4'h4, 16'hB09E, 1'b1},
    '{8'hEF, 8'hC2, 2, 4'h9, 4'h4, 16'hB09E, 1'b0},
    '{8'hEF, 8'hC0, 2, 4'hB, 4'h4, 16'hB09E, 1'b0},
    '{8'hC6, 8'h41, 2, 4'h1, 4'h4, 16'hB09E, 1'b0},
    '{8'h42, 8'h00, 1, 4'h9, 4'h4, 16'hB01E, 1'b0},
    '{8'h40, 8'h00, 1, 4'hB, 4'h4, 16'h901E, 1'b0},
    '{8'h41, 8'h00, 1, 4'h0, 4'h4, 16'h9B1E, 1'b0},
    '{8'h43, 8'h00, 1, 4'hE, 4'h4, 16'h9B10, 1'b0},
    '{8'hCF, 8'h05, 2, 4'hE, 4'h4, 16'h5B10, 1'b0},
    '{8'hCF, 8'h13, 2, 4'hE, 4'h4, 16'h5310, 1'b0},
    '{8'hEF, 8'hD1, 2, 4'hE, 4'h4, 16'h5E10, 1'b0},
    '{8'hEF, 8'hD3, 2, 4'hE, 4'h4, 16'h5E1E, 1'b0},
    '{8'h13, 8'h00, 1, 4'hE, 4'h4, 16'h5E1F, 1'b0},
    '{8'h13, 8'h00, 1, 4'hE, 4'h4, 16'h5E10, 1'b1}};

    // Program ROM stand-in: every byte differs with address and bank
    function automatic logic [7:0] rom_byte(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction
    assign rom_data = rom_byte(rom_addr);

    nlsp_decoder dut (
        .MCLK(mclk), .RST_B(rst_b), .INSTR_VALID(valid), .OPCODE(opcode),
        .OPERAND(operand), .INSTR_HIT(hit), .INSTR_READY(ready),
        .INSTR_DONE(done), .PC_IN(pc_in), .ROM_ADDR(rom_addr),
        .ROM_DATA(rom_data), .PORT4(port4), .PORT5(port5),
        .PORT_STROBE(strobe), .ACC(acc), .EXT(ext),
        .PRIMARY_HIGH_POINTER(ph), .PRIMARY_LOW_POINTER(pl),
        .SECONDARY_HIGH_POINTER(sh), .SECONDARY_LOW_POINTER(sl),
        .ZERO_FLAG(zf), .USER_FLAG_BIT(uf));

    // 40 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Compare seen against expected in 16 bits; the 17-bit zero flag and count check loses its top bit
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One instruction; cnt is the number of edges from take to done
    task automatic run_op(input logic [7:0] op, input logic [7:0] opnd,
                          output int cnt);
        @(posedge mclk);
        valid <= 1'b1;
        opcode <= op;
        operand <= opnd;
        @(posedge mclk);
        valid <= 1'b0;
        #1;
        cnt = 1;
        while (done !== 1'b1 && cnt < 8) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
    endtask

    // Memory is not reset, so seed it through the direct swap
    task automatic put(input logic [7:0] addr, input logic [3:0] val);
        int c;
        run_op(8'hC6, {4'h0, val}, c);
        run_op(8'hCC, addr, c);
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge mclk);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        final_report;
    end

    initial begin
        rst_b = 1'b0;
        valid = 1'b0;
        opcode = 8'h00;
        operand = 8'h00;
        pc_in = 13'h1A55;
        repeat (6) @(posedge mclk);
        #1;
        check({acc, ext, ph, pl}, 16'h0000);
        check({sh, sl, 7'h00, zf, strobe, done, ready}, 16'h0001);
        check(uf, 16'h0000);
        @(posedge mclk);
        rst_b <= 1'b1;
        put(8'h3C, 4'h9);
        put(8'h3D, 4'h0);
        put(8'h7F, 4'h2);
        put(8'h70, 4'hE);
        foreach (rows[i]) begin
            run_op(rows[i].op, rows[i].opnd, n);
            check(16'(n), 16'(rows[i].cyc));
            check(acc, rows[i].acc);
            check(ext, rows[i].ext);
            check({ph, pl, sh, sl}, rows[i].ptr);
            check(zf, rows[i].zf);
        end
        // Set all sixteen flags, then clear them in rising order
        for (int i = 0; i < 16; i++) begin
            run_op({4'h7, 4'(i)}, 8'h00, n);
            check(uf, 16'hFFFF >> (15 - i));
            check({zf, 16'(n)}, 17'h10001);
        end
        for (int i = 0; i < 16; i++) begin
            run_op({4'h3, 4'(i)}, 8'h00, n);
            check(uf, 16'hFFFF << (i + 1));
            check(zf, (i % 4 == 3));
        end
        // Table read, then table to ports from another bank
        run_op(8'hC6, 8'h37, n);
        run_op(8'h5A, 8'h00, n);
        e = rom_byte(13'h1A37);
        check(16'(n), 16'h0002);
        check(rom_addr, 13'h1A37);
        check({ext, acc}, e);
        @(posedge mclk);
        pc_in <= 13'h0B00;
        run_op(8'h58, 8'h00, n);
        check(16'(n), 16'h0002);
        check(rom_addr, {5'h0B, e});
        check({port5, port4}, rom_byte({5'h0B, e}));
        check({ext, acc, 7'h00, strobe}, {e, 8'h01});
        @(posedge mclk);
        #1;
        check({strobe, done}, 2'h0);
        // Reset in mid-run clears the registers but not the data memory
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check({acc, ext, ph, pl}, 16'h0000);
        check({sh, sl, 7'h00, zf, uf[0], ready}, 16'h0001);
        @(posedge mclk);
        rst_b <= 1'b1;
        // A request while busy is ignored; one-cycle forms run back to back
        @(posedge mclk);
        valid <= 1'b1;
        opcode <= 8'hC0;
        operand <= 8'h12;
        @(posedge mclk);
        opcode <= 8'h11;
        #1;
        check(ready, 1'b0);
        @(posedge mclk);
        #1;
        check({done, 3'h0, ph, pl}, 12'h812);
        @(posedge mclk);
        opcode <= 8'h13;
        @(posedge mclk);
        opcode <= 8'h80;
        #1;
        check(hit, 1'b0);
        @(posedge mclk);
        valid <= 1'b0;
        #1;
        check({ph, pl, sh, sl}, 16'h1301);
        @(posedge mclk);
        #1;
        check({done, acc, ph, pl}, 13'h0013);
        final_report;
    end
endmodule // nlsp_decoder_bench
